/* src/ulf_line_ctrl.sv */
// receive fifo and line format, line status and modem control logic of one channel
`timescale 1ns/1ps

// ****************************************
// small receive fifo, valid/ready on both sides
// ****************************************
module ulf_fifo #(
   parameter int W = 11,
   parameter int D = 4
) (
   input  wire logic         ref_clk,
   input  wire logic         rst,
   input  wire logic         clear,     // empties the fifo
   input  wire logic         in_valid,
   output logic             in_ready,
   input  wire logic [W-1:0] in_data,
   output logic             out_valid,
   input  wire logic         out_ready,
   output logic [W-1:0]     out_data
);
   localparam int AW = $clog2(D);
   logic [W-1:0] mem [D];        // storage
   logic [AW-1:0] wr_r;          // write pointer
   logic [AW-1:0] rd_r;          // read pointer
   logic [AW:0]   cnt_r;         // fill level
   logic          push;
   logic          pop;

   assign in_ready  = (cnt_r != (AW+1)'(D));
   assign out_valid = (cnt_r != '0);
   assign out_data  = mem[rd_r];
   assign push      = in_valid && in_ready;
   assign pop       = out_valid && out_ready;

   // storage write, no reset needed
   always_ff @(posedge ref_clk) begin
      if (push) begin
         mem[wr_r] <= in_data;
      end
   end

   // pointers and level
   always_ff @(posedge ref_clk) begin
      if (rst || clear) begin
         wr_r  <= '0;
         rd_r  <= '0;
         cnt_r <= '0;
      end else begin
         if (push) begin
            wr_r <= (wr_r == AW'(D-1)) ? '0 : wr_r + 1'b1;
         end
         if (pop) begin
            rd_r <= (rd_r == AW'(D-1)) ? '0 : rd_r + 1'b1;
         end
         cnt_r <= cnt_r + (AW+1)'(push) - (AW+1)'(pop);
      end
   end
endmodule : ulf_fifo

module ulf_line_ctrl
   import ulf_pkg::*;
#(
   parameter int RX_DEPTH = 4
) (
   input  wire logic       ref_clk,
   input  wire logic       rst,
   // host parallel bus
   input  wire logic [2:0] bus_addr,
   input  wire logic [7:0] bus_wdata,
   input  wire logic       bus_wr,           // one-cycle write strobe
   input  wire logic       bus_rd,           // one-cycle read strobe
   output logic     [7:0]  bus_rdata,
   // side inputs
   input  wire logic       enh_enable,       // enhanced_feature_control bit 4
   input  wire logic       auto_rts_en,
   input  wire logic       auto_rts_n,
   input  wire logic       clock_prescale_select_pin,
   input  wire logic       thr_fifo_empty,
   input  wire logic       tx_shift_empty,
   // receiver framing results
   input  wire logic       frame_done,       // one-cycle pulse per character
   input  wire logic [7:0] frame_chr,
   input  wire logic       frame_par_bit,
   input  wire logic       frame_stop_ok,
   input  wire logic       frame_line_low,   // line low for whole character
   // transmitter
   input  wire logic [7:0] tx_chr,
   input  wire logic       tx_serial,        // shifter output
   input  wire logic       rx_pin,
   output logic           tx_pin,
   output logic           rx_to_receiver,
   output logic           tx_par_bit,
   // format outputs
   output logic     [1:0]  word_len,
   output logic     [2:0]  stop_halves,
   output logic           parity_on,
   output logic           divisor_access,
   // modem and control outputs
   output logic           dtr_n,
   output logic           rts_n,
   output logic           irq_oe_n,
   output logic           ready_summary_en,
   output logic     [3:0]  loop_status,      // modem status bits 7:4 in loopback
   output logic           loop_active,
   output logic           xon_any_en,
   output logic           threshold_access,
   output logic           prescale_div4
);
   // ****************************************
   // registers and wires
   // ****************************************
   logic [7:0]    lfc_r;          // line_format_control
   logic [7:0]    mlc_r;          // modem_line_control
   logic          ovrn_r;         // overrun flag
   logic [3:0]    err_cnt_r;      // errored entries held
   logic          rst_d_r;        // reset seen last cycle
   logic          rx_clear;       // receive fifo clear
   logic          in_ready;
   logic          out_valid;
   logic          pop;
   logic          push;
   ulf_rx_entry_s new_ent;
   ulf_rx_entry_s head;
   logic [7:0]    mask;           // data bits in use
   logic          par_calc;       // parity of received char
   logic          par_exp;
   logic          tx_par_nxt;
   logic [7:0]    lsr_val;

   assign rx_clear = bus_wr && (bus_addr == ADDR_FIFO_CTL)
                     && bus_wdata[FC_RXCLR];
   // only a holding read pops; status reads never do
   assign pop = bus_rd && (bus_addr == ADDR_RX_HOLD)
                && !lfc_r[LF_DIVLAT];
   assign push = frame_done && in_ready;

   // ****************************************
   // receive character checks
   // ****************************************
   // mask off unused data bits
   always_comb begin
      unique case (lfc_r[1:0])
         2'h0:    mask = 8'h1F;
         2'h1:    mask = 8'h3F;
         2'h2:    mask = 8'h7F;
         2'h3:    mask = 8'hFF;
      endcase
   end

   // expected parity bit for a received char
   always_comb begin
      par_calc = ^(frame_chr & mask);
      if (lfc_r[LF_PAR_FX]) begin
         par_exp = !lfc_r[LF_PAR_EV];
      end else begin
         par_exp = lfc_r[LF_PAR_EV] ? par_calc : !par_calc;
      end
   end

   // build the entry; break forces char 00
   always_comb begin
      new_ent.brk = frame_line_low;
      new_ent.frm = !frame_stop_ok && !frame_line_low;
      new_ent.par = lfc_r[LF_PAR_EN] && !frame_line_low
                    && (frame_par_bit != par_exp);
      new_ent.chr = frame_line_low ? BREAK_CHAR : (frame_chr & mask);
   end

   // ****************************************
   // receive fifo
   // ****************************************
   // a full fifo refuses the character: that is an overrun
   ulf_fifo #(
      .W ($bits(ulf_rx_entry_s)),
      .D (RX_DEPTH)
   ) u_rx_fifo (
      .ref_clk   (ref_clk),
      .rst       (rst),
      .clear     (rx_clear),
      .in_valid  (frame_done),
      .in_ready  (in_ready),
      .in_data   (new_ent),
      .out_valid (out_valid),
      .out_ready (pop),
      .out_data  (head)
   );

   // ****************************************
   // line status flags
   // ****************************************
   // overrun: sticky, cleared by status read, set wins
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         ovrn_r <= 1'b0;
      end else if (frame_done && !in_ready) begin
         ovrn_r <= 1'b1;
      end else if (bus_rd && (bus_addr == ADDR_LINE_ST)) begin
         ovrn_r <= 1'b0;
      end
   end

   // count of errored entries held in the fifo
   // a read of an empty fifo is ignored, so a stale head never counts
   always_ff @(posedge ref_clk) begin
      if (rst || rx_clear) begin
         err_cnt_r <= '0;
      end else begin
         err_cnt_r <= err_cnt_r
            + 4'(push && (new_ent.brk || new_ent.frm || new_ent.par))
            - 4'(pop && out_valid
                 && (head.brk || head.frm || head.par));
      end
   end

   // assemble status byte; head error bits read zero while empty (stale slot)
   always_comb begin
      lsr_val            = 8'h00;
      lsr_val[LS_RXDATA] = out_valid;
      lsr_val[LS_OVRN]   = ovrn_r;
      lsr_val[4:2]       = out_valid ? {head.brk, head.frm, head.par} : 3'h0;
      lsr_val[LS_THRE]   = thr_fifo_empty;
      lsr_val[LS_TEMT]   = thr_fifo_empty && tx_shift_empty;
      lsr_val[LS_ERRSUM] = (err_cnt_r != '0);
   end

   // ****************************************
   // register writes
   // ****************************************
   // line format register
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         lfc_r <= LINE_FMT_RST;
      end else if (bus_wr && (bus_addr == ADDR_LINE_FMT)) begin
         lfc_r <= bus_wdata;
      end
   end

   // reset release detector for the strap
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         rst_d_r <= 1'b1;
      end else begin
         rst_d_r <= 1'b0;
      end
   end

   // modem control; top three bits guarded by enhanced enable
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         mlc_r <= MODEM_RST;
      end else if (rst_d_r) begin
         mlc_r[MC_DIV4] <= !clock_prescale_select_pin;
      end else if (bus_wr && (bus_addr == ADDR_MODEM)) begin
         mlc_r[4:0] <= bus_wdata[4:0];
         if (enh_enable) begin
            mlc_r[7:5] <= bus_wdata[7:5];
         end
      end
   end

   // ****************************************
   // read data, registered
   // ****************************************
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         bus_rdata <= 8'h00;
      end else if (bus_rd) begin
         unique case (bus_addr)
            ADDR_RX_HOLD:  bus_rdata <= head.chr;
            ADDR_LINE_FMT: bus_rdata <= lfc_r;
            ADDR_MODEM:    bus_rdata <= mlc_r;
            ADDR_LINE_ST:  bus_rdata <= lsr_val;
            default:       bus_rdata <= 8'h00;      // other blocks answer here
         endcase
      end
   end

   // ****************************************
   // serial pins and transmit parity
   // ****************************************
   // transmit parity bit for the current character
   always_comb begin
      if (lfc_r[LF_PAR_FX]) begin
         tx_par_nxt = !lfc_r[LF_PAR_EV];
      end else begin
         tx_par_nxt = lfc_r[LF_PAR_EV] ? ^(tx_chr & mask)
                                       : !(^(tx_chr & mask));
      end
   end

   // pins; loopback keeps the line idle high unless break is set, and feeds tx back
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         tx_pin         <= 1'b1;
         rx_to_receiver <= 1'b1;
         tx_par_bit     <= 1'b0;
      end else begin
         if (lfc_r[LF_BREAK]) begin
            tx_pin <= 1'b0;
         end else if (mlc_r[MC_LOOP]) begin
            tx_pin <= 1'b1;
         end else begin
            tx_pin <= tx_serial;
         end
         rx_to_receiver <= mlc_r[MC_LOOP] ? tx_serial : rx_pin;
         tx_par_bit     <= tx_par_nxt;
      end
   end

   // ****************************************
   // format outputs
   // ****************************************
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         word_len       <= LEN_5BIT;
         stop_halves    <= STOP_HALF_1;
         parity_on      <= 1'b0;
         divisor_access <= 1'b0;
      end else begin
         word_len  <= lfc_r[1:0];
         parity_on <= lfc_r[LF_PAR_EN];
         if (!lfc_r[LF_STOP]) begin
            stop_halves <= STOP_HALF_1;
         end else if (lfc_r[1:0] == LEN_5BIT) begin
            stop_halves <= STOP_HALF_15;
         end else begin
            stop_halves <= STOP_HALF_2;
         end
         divisor_access <= lfc_r[LF_DIVLAT];
      end
   end

   // ****************************************
   // modem outputs
   // ****************************************
   // in loopback dtr_n and rts_n go inactive; irq_oe_n and ready_summary_en still follow their bits; bits feed status too
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         dtr_n            <= 1'b1;
         rts_n            <= 1'b1;
         irq_oe_n         <= 1'b1;
         ready_summary_en <= 1'b0;
         loop_status      <= 4'h0;
         loop_active      <= 1'b0;
         xon_any_en       <= 1'b0;
         threshold_access <= 1'b0;
         prescale_div4    <= 1'b0;
      end else begin
         dtr_n <= mlc_r[MC_LOOP] || !mlc_r[MC_DTR];
         if (mlc_r[MC_LOOP]) begin
            rts_n <= 1'b1;
         end else if (auto_rts_en) begin
            rts_n <= auto_rts_n;
         end else begin
            rts_n <= !mlc_r[MC_RTS];
         end
         irq_oe_n         <= !mlc_r[MC_IRQEN];
         ready_summary_en <= mlc_r[MC_RDYSUM];
         loop_status      <= {mlc_r[MC_IRQEN], mlc_r[MC_RDYSUM],
                              mlc_r[MC_DTR], mlc_r[MC_RTS]};
         loop_active      <= mlc_r[MC_LOOP];
         xon_any_en       <= mlc_r[MC_XONANY];
         threshold_access <= mlc_r[MC_THRACC];
         prescale_div4    <= mlc_r[MC_DIV4];
      end
   end
endmodule : ulf_line_ctrl

/* src/ulf_pkg.sv */
// shared constants and types for the line format, status and modem control block
package ulf_pkg;
   // ****************************************
   // register addresses on the 3-bit bus
   // ****************************************
   localparam logic [2:0] ADDR_RX_HOLD  = 3'h0; // receive holding fifo (read)
   localparam logic [2:0] ADDR_FIFO_CTL = 3'h2; // fifo_control (write)
   localparam logic [2:0] ADDR_LINE_FMT = 3'h3; // line_format_control
   localparam logic [2:0] ADDR_MODEM    = 3'h4; // modem_line_control
   localparam logic [2:0] ADDR_LINE_ST  = 3'h5; // line_status
   // ****************************************
   // field positions
   // ****************************************
   localparam int LF_STOP   = 2;  // stop-bit select
   localparam int LF_PAR_EN = 3;  // parity enable
   localparam int LF_PAR_EV = 4;  // parity type
   localparam int LF_PAR_FX = 5;  // forced parity
   localparam int LF_BREAK  = 6;  // break control
   localparam int LF_DIVLAT = 7;  // divisor latch access
   localparam int MC_DTR    = 0;
   localparam int MC_RTS    = 1;
   localparam int MC_RDYSUM = 2;  // fifo_ready_summary enable
   localparam int MC_IRQEN  = 3;
   localparam int MC_LOOP   = 4;
   localparam int MC_XONANY = 5;
   localparam int MC_THRACC = 6;  // threshold/trigger access
   localparam int MC_DIV4   = 7;
   localparam int FC_RXCLR  = 1;  // receive fifo clear
   localparam int LS_RXDATA = 0;
   localparam int LS_OVRN   = 1;
   localparam int LS_THRE   = 5;
   localparam int LS_TEMT   = 6;
   localparam int LS_ERRSUM = 7;
   // ****************************************
   // reset values and small codes
   // ****************************************
   localparam logic [7:0] LINE_FMT_RST = 8'h00;
   localparam logic [7:0] MODEM_RST    = 8'h00;
   localparam logic [1:0] LEN_5BIT     = 2'h0;
   localparam logic [2:0] STOP_HALF_1  = 3'h2; // one stop bit, in half bits
   localparam logic [2:0] STOP_HALF_15 = 3'h3; // one and a half
   localparam logic [2:0] STOP_HALF_2  = 3'h4; // two
   localparam logic [7:0] BREAK_CHAR   = 8'h00;
   // one receive fifo entry: error bits plus character
   typedef struct packed {
      logic       brk;
      logic       frm;
      logic       par;
      logic [7:0] chr;
   } ulf_rx_entry_s;
endpackage : ulf_pkg

/* testbench/tb_ulf_line_ctrl.sv */
// self-checking bench for the line control block
`timescale 1ns/1ps
`define CHK(a, e) begin total_checks++; if ((a) !== (e)) begin fail_count++; \
   $display("Error at %0t: got %h want %h", $time, (a), (e)); end end
module tb_ulf_line_ctrl
   import ulf_pkg::*;
;
   // ********
   // signals
   // ********
   logic       ref_clk, rst, bus_wr, bus_rd, enh_enable, auto_rts_en, auto_rts_n, tx_serial;
   logic       clock_prescale_select_pin, thr_fifo_empty, tx_shift_empty;
   logic [2:0] bus_addr;
   logic [7:0] bus_wdata, tx_chr, bus_rdata, frame_chr;
   logic       frame_done, frame_par_bit, frame_stop_ok, frame_line_low, rx_pin, tx_pin;
   logic       rx_to_receiver, tx_par_bit, parity_on, divisor_access, dtr_n, rts_n, irq_oe_n;
   logic       ready_summary_en, loop_active, xon_any_en, threshold_access, prescale_div4;
   logic [1:0] word_len;
   logic [2:0] stop_halves;
   logic [3:0] loop_status;
   int         fail_count = 0;
   int         total_checks = 0;
   // parity settings and expected bit for character 80
   logic [7:0] par_fmt [5] = '{8'h0B, 8'h08, 8'h1B, 8'h2B, 8'h3B};
   logic       par_exp [5] = '{1'b0, 1'b1, 1'b1, 1'b1, 1'b0};

   ulf_line_ctrl #(.RX_DEPTH(4)) uut (.ref_clk, .rst, .bus_addr, .bus_wdata, .bus_wr, .bus_rd,
      .bus_rdata, .enh_enable, .auto_rts_en, .auto_rts_n, .clock_prescale_select_pin,
      .thr_fifo_empty, .tx_shift_empty, .frame_done, .frame_chr, .frame_par_bit, .frame_stop_ok,
      .frame_line_low, .tx_chr, .tx_serial, .rx_pin, .tx_pin, .rx_to_receiver, .tx_par_bit,
      .word_len, .stop_halves, .parity_on, .divisor_access, .dtr_n, .rts_n, .irq_oe_n,
      .ready_summary_en, .loop_status, .loop_active, .xon_any_en, .threshold_access,
      .prescale_div4);
   ulf_peer_model peer (.ref_clk, .frame_done, .frame_chr, .frame_par_bit, .frame_stop_ok,
      .frame_line_low, .rx_pin);

   // 10 MHz clock
   initial begin
      ref_clk = 1'b0;
      forever #50 ref_clk = ~ref_clk;
   end

   // ********
   // bus tasks
   // ********
   // write strobe for one edge, returns once outputs have settled
   task automatic wr(input logic [2:0] a, input logic [7:0] d);
      @(posedge ref_clk);
      bus_addr  <= a;
      bus_wdata <= d;
      bus_wr    <= 1'b1;
      @(posedge ref_clk);
      bus_wr    <= 1'b0;
      @(posedge ref_clk);
      @(negedge ref_clk);
   endtask : wr
   // read strobe, data compared half a cycle after it lands
   task automatic rd_chk(input logic [2:0] a, input logic [7:0] e);
      @(posedge ref_clk);
      bus_addr <= a;
      bus_rd   <= 1'b1;
      @(posedge ref_clk);
      bus_rd   <= 1'b0;
      @(negedge ref_clk);
      `CHK(bus_rdata, e)
   endtask : rd_chk
   // reset held 16 edges, strap set beforehand, first request 3 edges later
   task automatic do_reset(input logic pin);
      @(posedge ref_clk);
      clock_prescale_select_pin <= pin;
      rst <= 1'b1;
      repeat (16) @(posedge ref_clk);
      rst <= 1'b0;
      repeat (3) @(posedge ref_clk);
   endtask : do_reset
   // verdict and stop
   task automatic end_of_test;
      if (fail_count == 0 && total_checks > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask : end_of_test

   // hang guard
   initial begin
      repeat (20000) @(posedge ref_clk);
      fail_count++;
      end_of_test;
   end

   // ********
   // main sequence
   // ********
   initial begin
      {rst, bus_wr, bus_rd, enh_enable, auto_rts_en, auto_rts_n} = 6'b100000;
      {clock_prescale_select_pin, thr_fifo_empty, tx_shift_empty, tx_serial} = 4'hF;
      bus_addr = 3'h0;
      bus_wdata = 8'h00;
      tx_chr = 8'h80;
      do_reset(1'b1);
      rd_chk(ADDR_MODEM, 8'h00);
      rd_chk(ADDR_LINE_FMT, 8'h00);
      rd_chk(3'h7, 8'h00);
      rd_chk(ADDR_LINE_ST, 8'h60);
      // every length and stop select
      for (int i = 0; i < 8; i++) begin
         wr(ADDR_LINE_FMT, 8'(i));
         `CHK(word_len, i[1:0])
         `CHK(stop_halves, !i[2] ? STOP_HALF_1 : (i[1:0] == 0 ? STOP_HALF_15 : STOP_HALF_2))
         rd_chk(ADDR_LINE_FMT, 8'(i));
      end
      // odd, even and both forced values
      for (int j = 0; j < 5; j++) begin
         wr(ADDR_LINE_FMT, par_fmt[j]);
         `CHK({parity_on, tx_par_bit}, {1'b1, par_exp[j]})
      end
      wr(ADDR_LINE_FMT, 8'h43);
      `CHK(tx_pin, 1'b0)
      wr(ADDR_LINE_FMT, 8'h83);
      `CHK({tx_pin, divisor_access}, 2'b11)
      wr(ADDR_LINE_FMT, 8'h03);
      `CHK(divisor_access, 1'b0)
      // upper modem bits refused without enable
      wr(ADDR_MODEM, 8'hEF);
      rd_chk(ADDR_MODEM, 8'h0F);
      `CHK({dtr_n, rts_n, irq_oe_n, ready_summary_en}, 4'b0001)
      @(posedge ref_clk);
      {enh_enable, auto_rts_en, auto_rts_n, tx_serial} <= 4'hE;
      wr(ADDR_MODEM, 8'hE3);
      `CHK({rts_n, xon_any_en, threshold_access, prescale_div4}, 4'hF)
      rd_chk(ADDR_MODEM, 8'hE3);
      wr(ADDR_MODEM, 8'h1D);
      `CHK({loop_active, loop_status, rx_to_receiver, tx_pin, dtr_n}, 8'hF3)
      wr(ADDR_MODEM, 8'h00);
      `CHK({loop_active, rx_to_receiver, tx_pin}, 3'b010)
      // receive path: good then framing error
      peer.send(8'h41, 1'b0, 1'b1, 1'b0);
      peer.send(8'h42, 1'b0, 1'b0, 1'b0);
      rd_chk(ADDR_LINE_ST, 8'hE1);
      rd_chk(ADDR_LINE_ST, 8'hE1);
      rd_chk(ADDR_RX_HOLD, 8'h41);
      rd_chk(ADDR_LINE_ST, 8'hE9);
      rd_chk(ADDR_RX_HOLD, 8'h42);
      rd_chk(ADDR_LINE_ST, 8'h60);
      peer.send(8'h55, 1'b0, 1'b0, 1'b1);
      rd_chk(ADDR_LINE_ST, 8'hF1);
      rd_chk(ADDR_RX_HOLD, 8'h00);
      // wrong then right parity under odd 8-bit
      wr(ADDR_LINE_FMT, 8'h0B);
      peer.send(8'h00, 1'b0, 1'b1, 1'b0);
      rd_chk(ADDR_LINE_ST, 8'hE5);
      rd_chk(ADDR_RX_HOLD, 8'h00);
      peer.send(8'h00, 1'b1, 1'b1, 1'b0);
      rd_chk(ADDR_LINE_ST, 8'h61);
      rd_chk(ADDR_RX_HOLD, 8'h00);
      @(posedge ref_clk);
      tx_shift_empty <= 1'b0;
      for (int k = 0; k < 5; k++) peer.send(8'h01, 1'b0, 1'b1, 1'b0);
      rd_chk(ADDR_LINE_ST, 8'h23);
      rd_chk(ADDR_LINE_ST, 8'h21);
      wr(ADDR_FIFO_CTL, 8'h02);
      rd_chk(ADDR_LINE_ST, 8'h20);
      // second reset with the strap low
      do_reset(1'b0);
      rd_chk(ADDR_MODEM, 8'h80);
      rd_chk(ADDR_LINE_FMT, 8'h00);
      `CHK(prescale_div4, 1'b1)
      end_of_test;
   end
endmodule : tb_ulf_line_ctrl

/* testbench/ulf_line_ctrl_checker.sv */
// concurrent checks on the line control block ports
`timescale 1ns/1ps
module ulf_line_ctrl_checker
   import ulf_pkg::*;
(
   input wire logic       ref_clk,
   input wire logic       rst,
   input wire logic [2:0] bus_addr,
   input wire logic [7:0] bus_wdata,
   input wire logic       bus_wr,
   input wire logic       enh_enable,
   input wire logic       clock_prescale_select_pin,
   input wire logic [7:0] tx_chr,
   input wire logic       tx_serial,
   input wire logic       rx_pin,
   input wire logic       tx_pin,
   input wire logic       rx_to_receiver,
   input wire logic       tx_par_bit,
   input wire logic [1:0] word_len,
   input wire logic [2:0] stop_halves,
   input wire logic       parity_on,
   input wire logic       divisor_access,
   input wire logic       dtr_n,
   input wire logic       irq_oe_n,
   input wire logic       ready_summary_en,
   input wire logic [3:0] loop_status,
   input wire logic       loop_active,
   input wire logic       xon_any_en,
   input wire logic       threshold_access,
   input wire logic       prescale_div4
);
   // ********
   // shadow registers
   // ********
   logic [7:0] lf_r;    // last line format written
   logic [7:0] mc_r;    // modem control as it should stand
   logic [1:0] age_r;   // edges since last write, saturating
   logic       rst_d_r; // reset seen one edge ago
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (rst);

   // expected transmit parity bit, data masked to word length
   function automatic logic pbit(input logic [7:0] f, input logic [7:0] c);
      logic [7:0] m;
      m = c & (8'hFF >> (2'h3 - f[1:0]));
      return f[LF_PAR_FX] ? !f[LF_PAR_EV] : ((^m) ^ !f[LF_PAR_EV]);
   endfunction : pbit

   always_ff @(posedge ref_clk) begin
      rst_d_r <= rst;
   end
   // line format shadow
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         lf_r <= LINE_FMT_RST;
      end else if (bus_wr && bus_addr == ADDR_LINE_FMT) begin
         lf_r <= bus_wdata;
      end
   end
   // modem shadow: strap load first, upper bits guarded by enable
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         mc_r <= MODEM_RST;
      end else if (rst_d_r) begin
         mc_r[MC_DIV4] <= !clock_prescale_select_pin;
      end else if (bus_wr && bus_addr == ADDR_MODEM) begin
         mc_r <= enh_enable ? bus_wdata : {mc_r[7:5], bus_wdata[4:0]};
      end
   end
   // settle counter, gives outputs slack after any write
   always_ff @(posedge ref_clk) begin
      if (rst || rst_d_r || bus_wr) begin
         age_r <= 2'h0;
      end else if (age_r != 2'h3) begin
         age_r <= age_r + 2'h1;
      end
   end

   // ********
   // assertions
   // ********
   fmt_fields_a: assert property (age_r >= 2'h2 |-> word_len == lf_r[1:0]
      && parity_on == lf_r[LF_PAR_EN] && divisor_access == lf_r[LF_DIVLAT])
      else $error("format outputs off");
   stop_count_a: assert property (age_r >= 2'h2 |-> stop_halves ==
      (!lf_r[LF_STOP] ? STOP_HALF_1 : (lf_r[1:0] == LEN_5BIT ? STOP_HALF_15 : STOP_HALF_2)))
      else $error("stop length off");
   par_bit_a: assert property (age_r >= 2'h2 && lf_r[LF_PAR_EN] && $stable(tx_chr)
      |-> tx_par_bit == pbit(lf_r, tx_chr)) else $error("parity bit off");
   break_low_a: assert property (age_r >= 2'h2 && lf_r[LF_BREAK] && !mc_r[MC_LOOP]
      |-> !tx_pin) else $error("break not low");
   modem_ctl_a: assert property (age_r >= 2'h2 |-> dtr_n == (mc_r[MC_LOOP] | !mc_r[MC_DTR])
      && irq_oe_n == !mc_r[MC_IRQEN] && ready_summary_en == mc_r[MC_RDYSUM])
      else $error("modem outputs off");
   enh_bits_a: assert property (age_r >= 2'h2 |->
      {prescale_div4, threshold_access, xon_any_en} == mc_r[7:5]) else $error("upper bits off");
   loop_map_a: assert property (age_r >= 2'h2 |-> loop_active == mc_r[MC_LOOP] &&
      (!loop_active || loop_status == {mc_r[3], mc_r[2], mc_r[0], mc_r[1]}))
      else $error("loop status off");
   loop_rx_a: assert property (age_r == 2'h3 |->
      rx_to_receiver == $past(mc_r[MC_LOOP] ? tx_serial : rx_pin)) else $error("rx route off");
endmodule : ulf_line_ctrl_checker

bind ulf_line_ctrl ulf_line_ctrl_checker chk (.ref_clk, .rst, .bus_addr, .bus_wdata, .bus_wr,
   .enh_enable, .clock_prescale_select_pin, .tx_chr, .tx_serial, .rx_pin, .tx_pin,
   .rx_to_receiver, .tx_par_bit, .word_len, .stop_halves, .parity_on, .divisor_access, .dtr_n,
   .irq_oe_n, .ready_summary_en, .loop_status, .loop_active, .xon_any_en, .threshold_access,
   .prescale_div4);

/* testbench/ulf_peer_model.sv */
// serial peer model feeding received characters into the framing inputs
`timescale 1ns/1ps
module ulf_peer_model (
   input  wire logic       ref_clk,
   output logic            frame_done,
   output logic      [7:0] frame_chr,
   output logic            frame_par_bit,
   output logic            frame_stop_ok,
   output logic            frame_line_low,
   output logic            rx_pin
);
   // ********
   // idle state: line high, qualifiers hold junk
   // ********
   initial begin
      frame_done     = 1'b0;
      frame_chr      = 8'hA5;
      frame_par_bit  = 1'b0;
      frame_stop_ok  = 1'b0;
      frame_line_low = 1'b0;
      rx_pin         = 1'b1;
   end

   // one character, then qualifiers inverted so stale values never look valid
   task automatic send(input logic [7:0] chr, input logic par, input logic stp,
                       input logic low);
      @(posedge ref_clk);
      frame_chr      <= chr;
      frame_par_bit  <= par;
      frame_stop_ok  <= stp;
      frame_line_low <= low;
      rx_pin         <= ~low;
      frame_done     <= 1'b1;
      @(posedge ref_clk);
      frame_done     <= 1'b0;
      frame_chr      <= ~chr;
      frame_par_bit  <= ~par;
      frame_stop_ok  <= ~stp;
      frame_line_low <= ~low;
      rx_pin         <= 1'b1;
      @(posedge ref_clk);
   endtask : send
endmodule : ulf_peer_model
